// ==== logic/drsd_regs.svh ====
`ifndef DRSD_REGS_SVH
`define DRSD_REGS_SVH
// Register byte offsets
`define DRSD_OFS_STATUS 4'h0
`define DRSD_OFS_CTRL 4'h4
// Status fields
`define DRSD_ST_SLAVE 0
`define DRSD_ST_MODE_LO 1
`define DRSD_ST_PRESENT 3
`define DRSD_ST_SAMPLED 4
`define DRSD_ST_SELECTED 5
// Control fields
`define DRSD_CT_DASP 0
`define DRSD_CT_PDIAG 1
`define DRSD_CTRL_RST 2'h0
`endif

// ==== logic/drsd_pkg.sv ====
package drsd_pkg;
    typedef enum logic [1:0] {
        DET_PDIAG = 2'b00,
        DET_NONE = 2'b01,
        DET_DASP = 2'b10,
        DET_STRAP = 2'b11
    } drsd_det_t;
    typedef enum logic {
        ST_SAMPLE = 1'b0,
        ST_RUN = 1'b1
    } drsd_phase_t;
endpackage : drsd_pkg

// ==== logic/drsd_top.sv ====
// Summary of operation
// - No straps fitted: act as slave, handshake with master over PDIAG-.
// - Only slave-present strap: slave, never drive PDIAG- or DASP-.
// - Only drive-select strap: master, sense DASP- for an attached slave.
// - Drive-select plus slave-present: master, presence from strap only.
// - Cable-select strap alone: role from line, low master, high slave.
// - Cable select input is pulled up; open line reads high, slave.
// - Master answers as drive 0, slave answers as drive 1.
// - Cable select pin is role input only, no spindle synchronisation.
`timescale 1ns/100ps
`include "drsd_regs.svh"
module drsd_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Configuration straps
    input wire logic cable_select_strap,
    input wire logic drive_select_strap,
    input wire logic slave_present_strap,
    // Cable select line: high when the far end grounds it
    input wire logic csel_grounded,
    // Drive number currently addressed by the host
    input wire logic host_dev_bit,
    // DASP- open-drain pin
    input wire logic dasp_n_in,
    output logic dasp_n_out,
    output logic dasp_oe,
    // PDIAG- open-drain pin
    input wire logic pdiag_n_in,
    output logic pdiag_n_out,
    output logic pdiag_oe,
    // Decoded role
    output logic role_slave,
    output logic dev_selected,
    output logic slave_present,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef struct packed {
        drsd_pkg::drsd_phase_t phase;
        logic slave;
        drsd_pkg::drsd_det_t mode;
        logic present;
        logic selected;
        logic [1:0] ctrl;
        logic dasp_oe;
        logic pdiag_oe;
        logic [31:0] rdata;
        logic wait_n;
    } drsd_state_t;

    drsd_state_t q, d;
    logic req;
    logic csel_level;
    logic [31:0] status_word;

    assign req = avs_read | avs_write;
    // Internal pull-up: only a grounded line reads low
    assign csel_level = ~csel_grounded;

    always_comb begin
        status_word = 32'h0;
        status_word[`DRSD_ST_SLAVE] = q.slave;
        status_word[`DRSD_ST_MODE_LO +: 2] = q.mode;
        status_word[`DRSD_ST_PRESENT] = q.present;
        status_word[`DRSD_ST_SAMPLED] = q.phase == drsd_pkg::ST_RUN;
        status_word[`DRSD_ST_SELECTED] = q.selected;
    end

    always_comb begin
        d = q;
        d.wait_n = 1'b0;
        unique case (q.phase)
            drsd_pkg::ST_SAMPLE: begin
                // Pin 28 is only ever read as a role input
                if (cable_select_strap
                        && !drive_select_strap) begin
                    d.slave = csel_level;
                    d.mode = csel_level ? drsd_pkg::DET_PDIAG
                                        : drsd_pkg::DET_DASP;
                end else if (drive_select_strap) begin
                    // Both role straps fitted: drive-select decode rules
                    d.slave = 1'b0;
                    if (slave_present_strap) begin
                        d.mode = drsd_pkg::DET_STRAP;
                    end else begin
                        d.mode = drsd_pkg::DET_DASP;
                    end
                end else begin
                    d.slave = 1'b1;
                    if (slave_present_strap) begin
                        d.mode = drsd_pkg::DET_NONE;
                    end else begin
                        d.mode = drsd_pkg::DET_PDIAG;
                    end
                end
                // Strap presence counts only under drive-select decode
                d.present = drive_select_strap
                          && slave_present_strap;
                d.phase = drsd_pkg::ST_RUN;
            end
            drsd_pkg::ST_RUN: begin
                // Role and mode frozen; only presence may grow
                if (q.mode == drsd_pkg::DET_DASP && !dasp_n_in
                        && !q.dasp_oe) begin
                    d.present = 1'b1;
                end
            end
        endcase
        d.selected = q.phase == drsd_pkg::ST_RUN
                   && host_dev_bit == q.slave;
        // Master and slave both assert DASP-; a silent slave drives nothing
        d.dasp_oe = q.phase == drsd_pkg::ST_RUN
                  && q.mode != drsd_pkg::DET_NONE
                  && q.ctrl[`DRSD_CT_DASP];
        d.pdiag_oe = q.phase == drsd_pkg::ST_RUN
                   && q.mode == drsd_pkg::DET_PDIAG
                   && q.ctrl[`DRSD_CT_PDIAG];
        // One wait cycle per access; the edge with wait low completes it
        if (req && q.wait_n == 1'b0) begin
            d.wait_n = 1'b1;
            d.rdata = 32'h0;
            if (avs_read && avs_address == `DRSD_OFS_STATUS) begin
                d.rdata = status_word;
            end else if (avs_read && avs_address == `DRSD_OFS_CTRL) begin
                d.rdata = {30'h0, q.ctrl};
            end
        end
        if (req && q.wait_n && avs_write && avs_address == `DRSD_OFS_CTRL
                && avs_byteenable[0]) begin
            d.ctrl = avs_writedata[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '{phase: drsd_pkg::ST_SAMPLE, slave: 1'b1,
                   mode: drsd_pkg::DET_PDIAG, present: 1'b0,
                   selected: 1'b0, ctrl: `DRSD_CTRL_RST, dasp_oe: 1'b0,
                   pdiag_oe: 1'b0, rdata: 32'h0, wait_n: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Open-drain pins only ever pull low
    always_ff @(posedge clk_sys) begin
        dasp_n_out <= 1'b0;
        pdiag_n_out <= 1'b0;
    end

    assign dasp_oe = q.dasp_oe;
    assign pdiag_oe = q.pdiag_oe;
    assign role_slave = q.slave;
    assign dev_selected = q.selected;
    assign slave_present = q.present;
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = ~q.wait_n;

    AST_NONE_SILENT: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.mode == drsd_pkg::DET_NONE |-> !dasp_oe && !pdiag_oe)
        else $error("silent slave drives a pin");
    AST_ROLE_HELD: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.phase == drsd_pkg::ST_RUN
        |=> $stable(role_slave) && $stable(q.mode))
        else $error("role changed after sampling");
    AST_SAMPLE_ONCE: assert property (
        @(posedge clk_sys)
        $fell(reset) |-> ##1 q.phase == drsd_pkg::ST_RUN)
        else $error("straps not sampled after reset");
    AST_DSEL_MASTER: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.phase == drsd_pkg::ST_SAMPLE && drive_select_strap
        && !cable_select_strap |=> !role_slave)
        else $error("drive select did not give master");
    AST_STRAP_PRESENT: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.mode == drsd_pkg::DET_STRAP |-> slave_present && !pdiag_oe)
        else $error("strap presence not held");
    AST_CSEL_ROLE: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.phase == drsd_pkg::ST_SAMPLE && cable_select_strap
        && !drive_select_strap |=> role_slave == $past(~csel_grounded))
        else $error("cable select role wrong");
    AST_CSEL_NO_STRAP: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.phase == drsd_pkg::ST_SAMPLE && cable_select_strap
        && !drive_select_strap |=> !slave_present
        && q.mode != drsd_pkg::DET_STRAP
        && q.mode != drsd_pkg::DET_NONE)
        else $error("slave-present strap used under cable select");
    AST_OPEN_SLAVE: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.phase == drsd_pkg::ST_SAMPLE && cable_select_strap
        && !drive_select_strap && !csel_grounded |=> role_slave)
        else $error("open cable select line did not give slave");
    AST_DEV_MATCH: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.phase == drsd_pkg::ST_RUN
        |=> dev_selected == ($past(host_dev_bit) == $past(role_slave)))
        else $error("wrong drive number answered");
    AST_PDIAG_SLAVE: assert property (
        @(posedge clk_sys) disable iff (reset)
        pdiag_oe |-> role_slave && q.mode == drsd_pkg::DET_PDIAG)
        else $error("PDIAG driven outside compat slave");
    AST_DASP_SENSE: assert property (
        @(posedge clk_sys) disable iff (reset)
        q.mode == drsd_pkg::DET_DASP && !dasp_n_in && !dasp_oe
        |=> slave_present)
        else $error("slave on DASP- not noticed");
    AST_PRESENT_STICKY: assert property (
        @(posedge clk_sys) disable iff (reset)
        slave_present |=> slave_present)
        else $error("slave presence dropped");
    AST_SLAVE_NO_PRESENT: assert property (
        @(posedge clk_sys) disable iff (reset)
        role_slave |-> !slave_present)
        else $error("slave reports a slave present");
    AST_ONE_WAIT: assert property (
        @(posedge clk_sys) disable iff (reset)
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");
endmodule : drsd_top

// ==== verif/drsd_far_end.sv ====
`timescale 1ns/100ps
module drsd_far_end (
    // Our drive's open-drain enables
    input wire logic dasp_oe,
    input wire logic pdiag_oe,
    // Other drive and cable
    input wire logic peer_dasp,
    input wire logic first_on_cable,
    // Wire levels
    output logic dasp_n,
    output logic pdiag_n,
    output logic csel_grounded
);
    // Pull-ups: a released line reads high, never the last value
    assign dasp_n = !(dasp_oe || peer_dasp);
    assign pdiag_n = !pdiag_oe;
    // Host connector grounds the line; the cut cable leaves it open
    assign csel_grounded = first_on_cable;
endmodule : drsd_far_end

// ==== verif/drsd_top_tb.sv ====
`timescale 1ns/100ps
`include "drsd_regs.svh"
module drsd_top_tb;
    logic clk_sys = 0;
    logic reset = 1;
    logic csel = 0, dsel = 0, spres = 0, first = 0, peer = 0, dev_bit = 0;
    logic [3:0] adr = 4'h0, be = 4'hf;
    logic rd = 0, wr = 0;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic wait_rq, d_oe, p_oe, d_n, p_n, gnd, slv, sel, d_out, p_out, prs;
    logic [2:0] e;
    int errors = 0, checks_done = 0;
    integer seed = 32'hf9b743e7;
    always #5 clk_sys = ~clk_sys;
    drsd_far_end drsd_far_end_inst (.dasp_oe(d_oe), .pdiag_oe(p_oe),
        .peer_dasp(peer), .first_on_cable(first), .dasp_n(d_n),
        .pdiag_n(p_n), .csel_grounded(gnd));
    drsd_top drsd_top_inst (.clk_sys(clk_sys), .reset(reset),
        .cable_select_strap(csel), .drive_select_strap(dsel),
        .slave_present_strap(spres), .csel_grounded(gnd),
        .host_dev_bit(dev_bit), .dasp_n_in(d_n), .dasp_n_out(d_out),
        .dasp_oe(d_oe), .pdiag_n_in(p_n), .pdiag_n_out(p_out),
        .pdiag_oe(p_oe), .role_slave(slv), .dev_selected(sel),
        .slave_present(prs), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wait_rq));
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] x, s);
        checks_done++;
        if (s !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, x, s);
        end
    endtask : chk
    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input int d);
        adr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk_sys); while (wait_rq !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    // Status bits {mode, slave} for a strap setting and line state
    function automatic logic [2:0] exp_st(input logic c, d, p, g);
        if (d) return {1'b1, p, 1'b0};
        if (c) return g ? 3'b100 : 3'b001;
        return {1'b0, p, 1'b1};
    endfunction : exp_st
    task automatic run(input logic [3:0] k);
        reset <= 1'b1;
        {csel, dsel, spres, first} <= k;
        peer <= 1'($random(seed));
        dev_bit <= 1'($random(seed));
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        // Moving straps after sampling must leave the role alone
        {csel, dsel, spres, first} <= ~k;
        repeat (3) @(posedge clk_sys);
        e = exp_st(k[3], k[2], k[1], k[0]);
        bus(1'b0, `DRSD_OFS_STATUS, 0);
        chk("mode", e[2:1], got[2:1]);
        chk("slave", e[0], got[0]);
        chk("sampled", 1, got[4]);
        chk("role_slave", e[0], slv);
        chk("selected", dev_bit == e[0], sel);
        chk("sel_bit", dev_bit == e[0], got[5]);
        chk("present", e[2] & (e[1] | peer), got[3]);
        chk("present_pin", e[2] & (e[1] | peer), prs);
        // Host turns to the other drive; this write has byte 0 masked
        dev_bit <= ~dev_bit;
        be <= 4'he;
        bus(1'b1, `DRSD_OFS_CTRL, 3);
        chk("selected", dev_bit == e[0], sel);
        be <= 4'hf;
        bus(1'b0, `DRSD_OFS_CTRL, 0);
        chk("ctrl_masked", 0, got);
        bus(1'b1, `DRSD_OFS_CTRL, 3);
        bus(1'b0, `DRSD_OFS_CTRL, 0);
        chk("ctrl", 3, got);
        repeat (3) @(posedge clk_sys);
        chk("dasp_oe", e[2:0] != 3'b011, d_oe);
        chk("pdiag_oe", e[2:0] == 3'b001, p_oe);
        chk("pin_levels", 0, {d_out, p_out});
        bus(1'b0, 4'h8, 0);
        chk("unmapped", 0, got);
    endtask : run
    initial begin
        for (int i = 0; i < 24; i++) begin
            run(i < 16 ? 4'(i) : 4'($random(seed)));
        end
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        stop_test;
    end
endmodule : drsd_top_tb
